/* fci_params.svh */
`ifndef FCI_PARAMS_SVH
`define FCI_PARAMS_SVH
// ------------------------------------------------------------
// opcodes
// ------------------------------------------------------------
`define FCI_OP_NO_OPERATION 8'h00
`define FCI_OP_RST_ARM 8'h66
`define FCI_OP_RST 8'h99
`define FCI_OP_FAST_READ 8'h0B
`define FCI_OP_JEDEC_ID 8'h9F
`define FCI_OP_SIG 8'hAB
`define FCI_OP_MFR_ID 8'h90
`define FCI_OP_WRITE_ENABLE 8'h06
`define FCI_OP_WRITE_DISABLE 8'h04
`define FCI_OP_FACTORY_MODE 8'h41
`define FCI_OP_SUSPEND 8'hB0
`define FCI_OP_DUAL_READ 8'hBB
`define FCI_OP_PP 8'h02
`define FCI_OP_QPP 8'h38
`define FCI_OP_SE 8'h20
`define FCI_OP_BE32 8'h52
`define FCI_OP_BE 8'hD8
`define FCI_OP_CE1 8'h60
`define FCI_OP_CE2 8'hC7
// ------------------------------------------------------------
// identification bytes (arbitrary values)
// ------------------------------------------------------------
`define FCI_ID_MAKER 8'h5A
`define FCI_ID_TYPE 8'h11
`define FCI_ID_DENSITY 8'h22
`define FCI_ID_SIGNATURE 8'h22
// ------------------------------------------------------------
// read phase clocks
// ------------------------------------------------------------
`define FCI_ADDR_BITS 8'h18
`define FCI_DUMMY_QUAD_FAST 8'h04
`define FCI_DUMMY_SEL0 8'h08
`define FCI_DUMMY_SEL1 8'h0A
`define FCI_DUMMY_DUAL 8'h04
// ------------------------------------------------------------
// timing
// ------------------------------------------------------------
`define FCI_CLK_NS 20
`define FCI_REL_ONE_NS 30000
`define FCI_REL_TWO_NS 30000
`define FCI_REL_ONE_CYC ((`FCI_REL_ONE_NS + `FCI_CLK_NS - 1) / `FCI_CLK_NS)
`define FCI_REL_TWO_CYC ((`FCI_REL_TWO_NS + `FCI_CLK_NS - 1) / `FCI_CLK_NS)
`endif

/* fci_pkg.sv */
package fci_pkg;
    typedef enum logic [2:0] {
        FCI_ST_CMD, FCI_ST_ADDR, FCI_ST_WAIT, FCI_ST_OUT, FCI_ST_DROP
    } fci_state_e;
    typedef enum logic [1:0] {
        FCI_KIND_JEDEC, FCI_KIND_SIG, FCI_KIND_MFR
    } fci_kind_e;
endpackage

/* fci_core.sv */
`timescale 1ns/10ps
`include "fci_params.svh"
// Summary of operation
// R1 - soft reset only when reset opcode directly follows the reset-arm opcode
// R2 - any other command between arm and reset cancels that reset
// R3 - host avoids undefined opcodes; they are simply ignored here
// R4 - dual commands count address and dummy in 2-bit clock units
// R5 - read dummy clocks follow the dummy-cycle select bit; here only single-line fast read does, dual read fixed at four
// R6 - fast read in quad command mode uses exactly four dummy clocks
// R7 - write-enable frame sets the write-enable latch
// R8 - host sends write-enable before every program, erase or status write
// R9 - opcodes taken as 8 single-line clocks or 2 quad clocks
// R10 - write-disable frame clears the write-enable latch
// R11 - latch cleared by reset, pin, write-disable, completions, suspend, soft reset
// R12 - host sends write-enable, factory-mode, then program or erase
// R13 - suspend refused while factory mode is active
// R14 - factory mode cleared by resets, soft reset, program or erase completion
// R15 - three-byte id read gives maker byte then two device bytes
// R16 - three-byte id read not decoded while program or erase runs
// R17 - release ends at chip select high, delayed only from deep power-down
// R18 - reset pin low leaves deep power-down
// R19 - release and signature decoded in deep power-down unless busy
// R20 - signature repeats each byte; exit afterwards takes second release delay
// R21 - id read: opcode, two dummy bytes, address byte, msb first out
// R22 - address zero gives maker first, one device first, then alternate
// R23 - program and erase ignored unless write-enable latch is set
module fci_core
    import fci_pkg::*;
(
    input wire logic clk_in,
    input wire logic rst_n_in,
    input wire logic cs_n_in,
    input wire logic sclk_in,
    input wire logic [3:0] sio_in,
    input wire logic hw_reset_n_in,
    input wire logic quad_mode_in,
    input wire logic dummy_cycle_select_in,
    input wire logic busy_in,
    input wire logic op_done_in,
    input wire logic latch_clear_in,
    input wire logic dpd_enter_in,
    output logic [3:0] sio_out,
    output logic [3:0] sio_oe_out,
    output logic write_enable_latch_out,
    output logic factory_mode_out,
    output logic deep_power_down_out,
    output logic standby_out,
    output logic soft_reset_out,
    output logic pe_start_out,
    output logic [7:0] pe_opcode_out,
    output logic suspend_out,
    output logic [7:0] addr_clocks_out,
    output logic [7:0] dummy_clocks_out
);
    // ------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------
    function automatic logic fci_is_pe(input logic [7:0] op);
        fci_is_pe = (op == `FCI_OP_PP) || (op == `FCI_OP_QPP) || (op == `FCI_OP_SE) ||
                    (op == `FCI_OP_BE32) || (op == `FCI_OP_BE) ||
                    (op == `FCI_OP_CE1) || (op == `FCI_OP_CE2);
    endfunction
    function automatic logic [7:0] fci_id_byte(input fci_kind_e kind, input logic [1:0] idx);
        fci_id_byte = `FCI_ID_SIGNATURE;
        unique case (kind)
            FCI_KIND_JEDEC: begin
                fci_id_byte = (idx == 2'h0) ? `FCI_ID_MAKER :
                              (idx == 2'h1) ? `FCI_ID_TYPE : `FCI_ID_DENSITY; // R15
            end
            FCI_KIND_SIG: fci_id_byte = `FCI_ID_SIGNATURE; // R20
            FCI_KIND_MFR: fci_id_byte = idx[0] ? `FCI_ID_DENSITY : `FCI_ID_MAKER; // R22
        endcase
    endfunction

    // ------------------------------------------------------------
    // pin synchronisers
    // ------------------------------------------------------------
    logic [1:0] cs_sy_r, sclk_sy_r, hrst_sy_r;
    logic [3:0] sio_m_r, sio_s_r;
    logic cs_d_r, sclk_d_r;

    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            cs_sy_r <= 2'h3;
            sclk_sy_r <= 2'h0;
            hrst_sy_r <= 2'h3;
            sio_m_r <= 4'h0;
            sio_s_r <= 4'h0;
            cs_d_r <= 1'b1;
            sclk_d_r <= 1'b0;
        end else begin
            cs_sy_r <= {cs_sy_r[0], cs_n_in};
            sclk_sy_r <= {sclk_sy_r[0], sclk_in};
            hrst_sy_r <= {hrst_sy_r[0], hw_reset_n_in};
            sio_m_r <= sio_in;
            sio_s_r <= sio_m_r;
            cs_d_r <= cs_sy_r[1];
            sclk_d_r <= sclk_sy_r[1];
        end
    end

    logic selected, cs_rise, sck_rise, sck_fall, pin_reset;
    assign selected = !cs_sy_r[1];
    assign cs_rise = cs_sy_r[1] && !cs_d_r;
    assign sck_rise = selected && sclk_sy_r[1] && !sclk_d_r;
    assign sck_fall = selected && !sclk_sy_r[1] && sclk_d_r;
    assign pin_reset = !hrst_sy_r[1];

    // ------------------------------------------------------------
    // byte assembly
    // ------------------------------------------------------------
    fci_state_e st_r;
    logic [7:0] in_sh_r, op_r, in_nxt;
    logic [3:0] bit_cnt_r, step, cnt_nxt;
    logic [1:0] hdr_cnt_r;
    logic byte_end;

    assign step = quad_mode_in ? 4'h4 : 4'h1; // R9
    assign cnt_nxt = bit_cnt_r + step;
    // upper lines are don't-care in single-wire mode
    assign in_nxt = quad_mode_in ? {in_sh_r[3:0], sio_s_r} : {in_sh_r[6:0], sio_s_r[0]}; // R9
    assign byte_end = sck_rise && (cnt_nxt == 4'h8) &&
                      ((st_r == FCI_ST_CMD) || (st_r == FCI_ST_ADDR));

    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            in_sh_r <= 8'h00;
            bit_cnt_r <= 4'h0;
        end else if (!selected) begin
            bit_cnt_r <= 4'h0;
        end else if (sck_rise) begin
            in_sh_r <= in_nxt;
            bit_cnt_r <= (cnt_nxt == 4'h8) ? 4'h0 : cnt_nxt;
        end
    end

    // ------------------------------------------------------------
    // command state
    // ------------------------------------------------------------
    logic latch_r, fm_r, dpd_r;
    fci_kind_e kind_r;
    logic [1:0] idx_r;
    logic [7:0] out_sh_r;
    logic [3:0] out_cnt_r;
    logic out_any_r;

    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            st_r <= FCI_ST_CMD;
            op_r <= `FCI_OP_NO_OPERATION;
            hdr_cnt_r <= 2'h0;
            kind_r <= FCI_KIND_SIG;
        end else if (!selected) begin
            st_r <= FCI_ST_CMD;
            hdr_cnt_r <= 2'h0;
        end else if (byte_end && st_r == FCI_ST_CMD) begin
            op_r <= in_nxt;
            if (dpd_r && in_nxt != `FCI_OP_SIG) begin
                st_r <= FCI_ST_DROP; // R19
            end else if (in_nxt == `FCI_OP_JEDEC_ID) begin
                st_r <= (busy_in || quad_mode_in) ? FCI_ST_DROP : FCI_ST_OUT; // R16
                kind_r <= FCI_KIND_JEDEC;
            end else if (in_nxt == `FCI_OP_SIG) begin
                st_r <= busy_in ? FCI_ST_DROP : FCI_ST_OUT; // R19
                kind_r <= FCI_KIND_SIG;
            end else if (in_nxt == `FCI_OP_MFR_ID) begin
                st_r <= (busy_in || quad_mode_in) ? FCI_ST_DROP : FCI_ST_ADDR;
                kind_r <= FCI_KIND_MFR;
            end else begin
                st_r <= FCI_ST_WAIT;
            end
        end else if (byte_end && st_r == FCI_ST_ADDR) begin
            hdr_cnt_r <= hdr_cnt_r + 2'h1;
            if (hdr_cnt_r == 2'h2) begin
                st_r <= FCI_ST_OUT; // R21
            end
        end else if (sck_rise && st_r == FCI_ST_WAIT) begin
            st_r <= FCI_ST_DROP; // R9
        end
    end

    // ------------------------------------------------------------
    // id shift-out
    // ------------------------------------------------------------
    logic entering_out;
    logic [1:0] first_idx;
    assign first_idx = (st_r == FCI_ST_ADDR) ? {1'b0, in_nxt[0]} : 2'h0; // R22
    assign entering_out = byte_end && (
        (st_r == FCI_ST_CMD && !(dpd_r && in_nxt != `FCI_OP_SIG) && !busy_in &&
         (in_nxt == `FCI_OP_SIG || (in_nxt == `FCI_OP_JEDEC_ID && !quad_mode_in))) ||
        (st_r == FCI_ST_ADDR && hdr_cnt_r == 2'h2));

    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            out_sh_r <= 8'h00;
            out_cnt_r <= 4'h0;
            idx_r <= 2'h0;
            out_any_r <= 1'b0;
            sio_out <= 4'h0;
            sio_oe_out <= 4'h0;
        end else if (!selected) begin
            out_any_r <= out_any_r && !cs_rise;
            sio_oe_out <= 4'h0;
        end else if (entering_out) begin
            idx_r <= first_idx;
            out_cnt_r <= 4'h0;
            out_any_r <= 1'b0;
            out_sh_r <= fci_id_byte(
                (st_r == FCI_ST_ADDR) ? FCI_KIND_MFR :
                (in_nxt == `FCI_OP_SIG) ? FCI_KIND_SIG : FCI_KIND_JEDEC, first_idx);
            sio_oe_out <= quad_mode_in ? 4'hF : 4'h2;
        end else if (sck_fall && st_r == FCI_ST_OUT) begin
            // msb first on the falling edge
            sio_out <= quad_mode_in ? out_sh_r[7:4] : {2'h0, out_sh_r[7], 1'b0}; // R21
            if (out_cnt_r + step == 4'h8) begin
                out_cnt_r <= 4'h0;
                out_any_r <= 1'b1;
                if (kind_r == FCI_KIND_JEDEC && idx_r == 2'h2) begin
                    idx_r <= 2'h0;
                    out_sh_r <= fci_id_byte(kind_r, 2'h0);
                end else begin
                    idx_r <= idx_r + 2'h1;
                    out_sh_r <= fci_id_byte(kind_r, idx_r + 2'h1);
                end
            end else begin
                out_cnt_r <= out_cnt_r + step;
                out_sh_r <= quad_mode_in ? {out_sh_r[3:0], 4'h0} : {out_sh_r[6:0], 1'b0};
            end
        end
    end

    // ------------------------------------------------------------
    // frame completion and latches
    // ------------------------------------------------------------
    logic frame_ok, arm_r, do_reset, sus_ok;
    assign frame_ok = cs_rise && (st_r == FCI_ST_WAIT);
    assign do_reset = frame_ok && op_r == `FCI_OP_RST && arm_r; // R1
    assign sus_ok = byte_end && st_r == FCI_ST_CMD && !dpd_r &&
                    in_nxt == `FCI_OP_SUSPEND && busy_in && !fm_r; // R13

    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            arm_r <= 1'b0;
        end else if (pin_reset) begin
            arm_r <= 1'b0;
        end else if (cs_rise && st_r != FCI_ST_CMD) begin
            arm_r <= frame_ok && op_r == `FCI_OP_RST_ARM; // R2
        end
    end

    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            latch_r <= 1'b0;
        end else if (pin_reset) begin
            latch_r <= 1'b0; // R11
        end else if (frame_ok && op_r == `FCI_OP_WRITE_ENABLE) begin
            latch_r <= 1'b1; // R7
        end else if ((frame_ok && op_r == `FCI_OP_WRITE_DISABLE) || do_reset || sus_ok ||
                     op_done_in || latch_clear_in) begin
            latch_r <= 1'b0; // R10 R11
        end
    end

    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            fm_r <= 1'b0;
        end else if (pin_reset) begin
            fm_r <= 1'b0; // R14
        end else if (frame_ok && op_r == `FCI_OP_FACTORY_MODE) begin
            fm_r <= 1'b1;
        end else if (do_reset || op_done_in) begin
            fm_r <= 1'b0; // R14
        end
    end

    // ------------------------------------------------------------
    // command pulses and read phase lengths
    // ------------------------------------------------------------
    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            soft_reset_out <= 1'b0;
            pe_start_out <= 1'b0;
            pe_opcode_out <= 8'h00;
            suspend_out <= 1'b0;
            addr_clocks_out <= 8'h00;
            dummy_clocks_out <= 8'h00;
        end else begin
            soft_reset_out <= do_reset && !pin_reset; // R1
            suspend_out <= sus_ok && !pin_reset;
            pe_start_out <= byte_end && st_r == FCI_ST_CMD && !dpd_r && !busy_in &&
                            fci_is_pe(in_nxt) && latch_r; // R23
            if (byte_end && st_r == FCI_ST_CMD) begin
                pe_opcode_out <= in_nxt;
                if (in_nxt == `FCI_OP_FAST_READ) begin
                    addr_clocks_out <= quad_mode_in ? (`FCI_ADDR_BITS >> 2) : `FCI_ADDR_BITS;
                    dummy_clocks_out <= quad_mode_in ? `FCI_DUMMY_QUAD_FAST : // R6
                        (dummy_cycle_select_in ? `FCI_DUMMY_SEL1 : `FCI_DUMMY_SEL0); // R5
                end else if (in_nxt == `FCI_OP_DUAL_READ) begin
                    addr_clocks_out <= `FCI_ADDR_BITS >> 1; // R4
                    dummy_clocks_out <= `FCI_DUMMY_DUAL; // R4
                end
            end
        end
    end

    // ------------------------------------------------------------
    // deep power-down and release delay
    // ------------------------------------------------------------
    logic [15:0] rel_cnt_r;
    logic release_now;
    assign release_now = cs_rise && st_r == FCI_ST_OUT && kind_r == FCI_KIND_SIG && dpd_r &&
                         rel_cnt_r == 16'h0000; // R17 R19

    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            dpd_r <= 1'b0;
            rel_cnt_r <= 16'h0000;
            standby_out <= 1'b1;
        end else begin
            standby_out <= !dpd_r && rel_cnt_r == 16'h0000;
            if (pin_reset) begin
                dpd_r <= 1'b0; // R18
                rel_cnt_r <= 16'h0000;
            end else if (release_now) begin
                rel_cnt_r <= out_any_r ? 16'(`FCI_REL_TWO_CYC) : 16'(`FCI_REL_ONE_CYC); // R20 R17
            end else if (rel_cnt_r != 16'h0000) begin
                rel_cnt_r <= rel_cnt_r - 16'h0001;
                if (rel_cnt_r == 16'h0001) begin
                    dpd_r <= 1'b0; // R17
                end
            end else if (dpd_enter_in && !busy_in) begin
                dpd_r <= 1'b1;
            end
        end
    end

    assign write_enable_latch_out = latch_r;
    assign factory_mode_out = fm_r;
    assign deep_power_down_out = dpd_r;
endmodule

/* fci_core_assertions.sv */
`timescale 1ns/10ps
module fci_core_chk (
    input wire logic clk_in,
    input wire logic rst_n_in,
    input wire logic cs_n_in,
    input wire logic hw_reset_n_in,
    input wire logic quad_mode_in,
    input wire logic busy_in,
    input wire logic op_done_in,
    input wire logic [3:0] sio_oe_out,
    input wire logic write_enable_latch_out,
    input wire logic factory_mode_out,
    input wire logic deep_power_down_out,
    input wire logic standby_out,
    input wire logic soft_reset_out,
    input wire logic pe_start_out,
    input wire logic suspend_out
);
    default clocking @(posedge clk_in); endclocking
    default disable iff (!rst_n_in);
    // ----------------------------------------
    // checks
    // ----------------------------------------
    a_pin_reset_clear: assert property (
        !hw_reset_n_in [*5] |-> !write_enable_latch_out && !factory_mode_out
            && !deep_power_down_out) else $error("pin reset left state set");
    a_pe_needs_latch: assert property (
        pe_start_out |-> $past(write_enable_latch_out)) else $error("program without latch");
    a_suspend_gate: assert property (
        suspend_out |-> $past(busy_in) && !$past(factory_mode_out))
        else $error("suspend accepted wrongly");
    a_soft_reset_clear: assert property (
        soft_reset_out |-> ##[0:1] (!write_enable_latch_out && !factory_mode_out))
        else $error("soft reset kept flags");
    a_done_clear: assert property (
        op_done_in && cs_n_in |-> ##[1:2] (!write_enable_latch_out && !factory_mode_out))
        else $error("completion kept flags");
    a_oe_idle: assert property (
        cs_n_in [*5] |-> sio_oe_out == 4'h0) else $error("driving while deselected");
    a_oe_width: assert property (
        sio_oe_out != 4'h0 |-> sio_oe_out == (quad_mode_in ? 4'hF : 4'h2))
        else $error("wrong output lines");
    a_busy_no_id: assert property (
        $rose(sio_oe_out != 4'h0) |-> !busy_in) else $error("id decoded while busy");
    a_dpd_no_standby: assert property (
        deep_power_down_out [*2] |-> !standby_out) else $error("standby in power-down");
    a_release_standby: assert property (
        $fell(deep_power_down_out) |-> ##[0:2] standby_out) else $error("no standby");
endmodule
bind fci_core fci_core_chk chk_u (.*);

/* fci_host.sv */
`timescale 1ns/10ps
module fci_host (
    output logic cs_n_out,
    output logic sclk_out,
    output logic [3:0] sio_out,
    input wire logic [3:0] sio_in
);
    // ----------------------------------------
    // framing; clock stands low outside frames
    // ----------------------------------------
    initial begin
        cs_n_out = 1'b1;
        sclk_out = 1'b0;
        sio_out = 4'h5;
    end
    task automatic open_f();
        cs_n_out = 1'b0;
        #80;
    endtask
    task automatic close_f(input int gap);
        #80 cs_n_out = 1'b1;
        sio_out = ~sio_out;
        #(gap);
    endtask
    // one byte out, one byte in, msb first
    task automatic xfer(input logic [7:0] b, input logic quad, input logic [3:0] noise,
                        output logic [7:0] rd);
        rd = 8'h00;
        for (int i = 0; i < (quad ? 2 : 8); i++) begin
            sio_out = quad ? (i == 0 ? b[7:4] : b[3:0]) : {noise[3:1], b[7 - i]};
            #80 sclk_out = 1'b1;
            rd = quad ? {rd[3:0], sio_in} : {rd[6:0], sio_in[1]};
            #80 sclk_out = 1'b0;
        end
    endtask
endmodule

/* fci_core_bench.sv */
`timescale 1ns/10ps
`include "fci_params.svh"
`define CHK(nm, ex, got) \
    begin \
        cmp_count++; \
        if ((got) !== (ex)) begin \
            n_mismatch++; \
            $display("unexpected %s expected %h seen %h", nm, ex, got); \
        end \
    end
module fci_core_bench;
    logic clk_in, rst_n_in, hw_n, quad, dcs, busy, op_done, latch_clr, dpd_in;
    logic cs_n, sclk, latch, fm, dpd, stby, srst, pes, susp;
    logic [3:0] sio_h, sio_d, oe, sio_w;
    logic [7:0] addrc, dumc, peop;
    logic [7:0] got [4];
    logic [31:0] rs = 32'hCB4AC824;
    int n_mismatch = 0, cmp_count = 0, n_pe = 0, n_sus = 0, n_srst = 0, n_oe = 0, cnt;
    assign sio_w = (oe & sio_d) | (~oe & sio_h);
    fci_host host_u (.cs_n_out(cs_n), .sclk_out(sclk), .sio_out(sio_h), .sio_in(sio_w));
    fci_core dut_u (.clk_in(clk_in), .rst_n_in(rst_n_in), .cs_n_in(cs_n), .sclk_in(sclk),
        .sio_in(sio_w), .hw_reset_n_in(hw_n), .quad_mode_in(quad),
        .dummy_cycle_select_in(dcs), .busy_in(busy), .op_done_in(op_done),
        .latch_clear_in(latch_clr), .dpd_enter_in(dpd_in), .sio_out(sio_d), .sio_oe_out(oe),
        .write_enable_latch_out(latch), .factory_mode_out(fm), .deep_power_down_out(dpd),
        .standby_out(stby), .soft_reset_out(srst), .pe_start_out(pes),
        .pe_opcode_out(peop), .suspend_out(susp), .addr_clocks_out(addrc),
        .dummy_clocks_out(dumc));
    initial begin
        clk_in = 1'b0;
        forever #10 clk_in = ~clk_in;
    end
    always @(posedge clk_in) begin
        n_pe += (pes === 1'b1);
        n_sus += (susp === 1'b1);
        n_srst += (srst === 1'b1);
        n_oe += (oe !== 4'h0);
    end
    // ----------------------------------------
    // helpers
    // ----------------------------------------
    function automatic logic [31:0] xs(input logic [31:0] s);
        s = s ^ (s << 13);
        s = s ^ (s >> 17);
        return s ^ (s << 5);
    endfunction
    function automatic logic [7:0] exp_id(input logic [7:0] op, input int i);
        if (op == `FCI_OP_SIG) return `FCI_ID_SIGNATURE;
        if (op == `FCI_OP_MFR_ID) return i % 2 == 0 ? `FCI_ID_MAKER : `FCI_ID_DENSITY;
        return i % 3 == 0 ? `FCI_ID_MAKER : (i % 3 == 1 ? `FCI_ID_TYPE : `FCI_ID_DENSITY);
    endfunction
    function automatic logic [7:0] exp_dum(input logic [7:0] op, input logic q, input logic d);
        if (op == `FCI_OP_DUAL_READ) return `FCI_DUMMY_DUAL;
        if (q) return `FCI_DUMMY_QUAD_FAST;
        return d ? `FCI_DUMMY_SEL1 : `FCI_DUMMY_SEL0;
    endfunction
    task automatic tick(input int n);
        repeat (n) @(posedge clk_in);
        #1;
    endtask
    task automatic done_t(input string s);
        $display("test %s finished", s);
    endtask
    task automatic frame(input logic [7:0] op, input int nd, input logic [7:0] ad,
                         input int nr, input int gap);
        logic [7:0] rd;
        rs = xs(rs);
        host_u.open_f();
        host_u.xfer(op, quad, rs[3:0], rd);
        for (int i = 0; i < nd + nr; i++) begin
            rs = xs(rs);
            host_u.xfer(i == nd - 1 ? ad : rs[7:0], quad, rs[11:8], rd);
            if (i >= nd) got[i - nd] = rd;
        end
        host_u.close_f(gap);
        if (gap > 0) tick(6);
    endtask
    task automatic pulse(input int k);
        case (k)
            0: op_done = 1'b1;
            1: latch_clr = 1'b1;
            default: dpd_in = 1'b1;
        endcase
        tick(1);
        op_done = 1'b0;
        latch_clr = 1'b0;
        dpd_in = 1'b0;
        tick(4);
    endtask
    task automatic release_wait(input logic [7:0] op, input int nr);
        int dl;
        dl = nr > 0 ? `FCI_REL_TWO_CYC : `FCI_REL_ONE_CYC;
        pulse(2);
        frame(op, 0, 8'h00, nr, 0);
        for (cnt = 0; dpd !== 1'b0 && cnt < 3000; cnt++) tick(1);
        `CHK("release delay", 1'b1, cnt >= dl && cnt <= dl + 8)
        if (cnt >= 3000) wrap_up();
        tick(4);
        `CHK("standby", 1'b1, stby)
    endtask
    task automatic wrap_up();
        $display("comparisons %0d mismatches %0d", cmp_count, n_mismatch);
        if (n_mismatch == 0 && cmp_count > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask
    initial begin
        #1000000;
        n_mismatch++;
        wrap_up();
    end
    // ----------------------------------------
    // scenarios
    // ----------------------------------------
    initial begin
        {rst_n_in, quad, dcs, busy, op_done, latch_clr, dpd_in} = 7'h00;
        hw_n = 1'b1;
        tick(12);
        rst_n_in = 1'b1;
        tick(6);
        for (int m = 0; m < 2; m++) begin
            quad = m[0];
            frame(`FCI_OP_WRITE_ENABLE, 0, 8'h00, 0, 200);
            `CHK("latch set", 1'b1, latch)
            frame(`FCI_OP_WRITE_DISABLE, 0, 8'h00, 0, 200);
            `CHK("latch clear", 1'b0, latch)
        end
        quad = 1'b0;
        frame(`FCI_OP_WRITE_ENABLE, 0, 8'h00, 0, 200);
        pulse(1);
        `CHK("latch clear pulse", 1'b0, latch)
        frame(`FCI_OP_PP, 0, 8'h00, 0, 200);
        `CHK("program refused", 0, n_pe)
        done_t("latch");
        frame(`FCI_OP_WRITE_ENABLE, 0, 8'h00, 0, 200);
        frame(`FCI_OP_FACTORY_MODE, 0, 8'h00, 0, 200);
        `CHK("factory set", 1'b1, fm)
        frame(`FCI_OP_SE, 0, 8'h00, 0, 200);
        `CHK("erase start", 1, n_pe)
        `CHK("erase opcode", `FCI_OP_SE, peop)
        busy = 1'b1;
        frame(`FCI_OP_SUSPEND, 0, 8'h00, 0, 200);
        `CHK("suspend refused", 0, n_sus)
        n_oe = 0;
        frame(`FCI_OP_JEDEC_ID, 0, 8'h00, 2, 200);
        `CHK("id while busy", 0, n_oe)
        pulse(0);
        `CHK("latch done", 1'b0, latch)
        `CHK("factory done", 1'b0, fm)
        frame(`FCI_OP_SUSPEND, 0, 8'h00, 0, 200);
        `CHK("suspend taken", 1, n_sus)
        busy = 1'b0;
        done_t("factory");
        frame(`FCI_OP_WRITE_ENABLE, 0, 8'h00, 0, 200);
        frame(`FCI_OP_RST_ARM, 0, 8'h00, 0, 200);
        frame(`FCI_OP_NO_OPERATION, 0, 8'h00, 0, 200);
        frame(`FCI_OP_RST, 0, 8'h00, 0, 200);
        `CHK("reset ignored", 0, n_srst)
        frame(`FCI_OP_RST_ARM, 0, 8'h00, 0, 200);
        frame(`FCI_OP_RST, 0, 8'h00, 0, 200);
        `CHK("reset taken", 1, n_srst)
        `CHK("latch soft reset", 1'b0, latch)
        done_t("reset");
        for (int k = 0; k < 4; k++) begin
            automatic logic [7:0] op = k == 0 ? `FCI_OP_JEDEC_ID :
                (k == 3 ? `FCI_OP_SIG : `FCI_OP_MFR_ID);
            frame(op, op == `FCI_OP_MFR_ID ? 3 : 0, {7'h00, k == 2}, 4, 200);
            for (int i = 0; i < 4; i++) begin
                `CHK("id byte", exp_id(op, i + (k == 2)), got[i])
            end
        end
        quad = 1'b1;
        frame(`FCI_OP_SIG, 0, 8'h00, 1, 200);
        `CHK("quad signature", `FCI_ID_SIGNATURE, got[0])
        quad = 1'b0;
        done_t("ids");
        for (int k = 0; k < 4; k++) begin
            quad = k == 2;
            dcs = k == 1;
            frame(k == 3 ? `FCI_OP_DUAL_READ : `FCI_OP_FAST_READ, 0, 8'h00, 0, 200);
            `CHK("dummy", exp_dum(k == 3 ? `FCI_OP_DUAL_READ : 8'h00, quad, dcs), dumc)
            if (k == 3) `CHK("dual addr", 8'h0C, addrc)
        end
        quad = 1'b0;
        done_t("dummy");
        pulse(2);
        `CHK("power-down", 1'b1, dpd)
        frame(`FCI_OP_WRITE_ENABLE, 0, 8'h00, 0, 200);
        `CHK("latch in power-down", 1'b0, latch)
        busy = 1'b1;
        frame(`FCI_OP_SIG, 0, 8'h00, 0, 200);
        tick(1600);
        `CHK("busy release", 1'b1, dpd)
        busy = 1'b0;
        release_wait(`FCI_OP_SIG, 0);
        release_wait(`FCI_OP_SIG, 1);
        `CHK("signature", `FCI_ID_SIGNATURE, got[0])
        pulse(2);
        hw_n = 1'b0;
        tick(8);
        `CHK("pin release", 1'b0, dpd)
        hw_n = 1'b1;
        tick(6);
        done_t("power-down");
        wrap_up();
    end
endmodule
